// file: clto_auto.sv
// automatic timing values scaled by the lane rate
`timescale 1ns/100ps

module clto_auto #(
    parameter clto_pkg::clto_timing_t BASE = 49'h0
) (
    input  wire logic                 clk,
    input  wire logic                 rst_n,
    input  wire logic [1:0]           rate_sel,
    output clto_pkg::clto_timing_t    auto_val
);

    logic [6:0][6:0] base_arr;
    logic [6:0][6:0] next_arr;
    logic [2:0]      mult;
    clto_pkg::clto_timing_t auto_reg;

    assign base_arr = BASE;
    assign mult     = {1'b0, rate_sel} + 3'h1;

    genvar i;
    generate
        for (i = 0; i < 7; i = i + 1) begin : g_scale
            logic [9:0] prod;
            assign prod = 10'(base_arr[i]) * 10'(mult);
            // saturate at the field's full scale
            assign next_arr[i] = (|prod[9:7]) ? 7'h7f : prod[6:0];
        end
    endgenerate

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            auto_reg <= '0;
        end else begin
            auto_reg <= clto_pkg::clto_timing_t'(next_arr);
        end
    end

    assign auto_val = auto_reg;

endmodule : clto_auto

// file: clto_field.sv
// one timing register: override bit, stored value, effective value
`timescale 1ns/100ps
`include "clto_map.svh"

module clto_field #(
    parameter logic [7:0] ADDR = `CLTO_CLK_PREPARE_OFF
) (
    input  wire logic                 clk,
    input  wire logic                 rst_n,
    input  wire logic                 wr_stb,
    input  wire logic [7:0]           addr,
    input  wire logic [7:0]           wdata,
    input  wire clto_pkg::clto_val_t  auto_val,
    output logic                      hit,
    output logic [7:0]                rd_byte,
    output clto_pkg::clto_val_t       eff_val
);

    logic                ov_reg;
    logic                ov_next;
    clto_pkg::clto_val_t val_reg;
    clto_pkg::clto_val_t val_next;
    logic                wr_take;
    logic                val_take;

    assign hit      = (addr == ADDR);
    assign wr_take  = wr_stb & hit;
    // value lands only when the written byte has the override bit set
    assign val_take = wr_take & wdata[`CLTO_OV_BIT];
    assign ov_next  = wr_take ? wdata[`CLTO_OV_BIT] : ov_reg;
    assign val_next = val_take ? wdata[`CLTO_VAL_MSB:`CLTO_VAL_LSB]
                               : val_reg;
    assign eff_val  = ov_reg ? val_reg : auto_val;
    assign rd_byte  = {ov_reg, eff_val};

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            ov_reg  <= `CLTO_OV_RESET;
            val_reg <= `CLTO_VAL_RESET;
        end else begin
            ov_reg  <= ov_next;
            val_reg <= val_next;
        end
    end

endmodule : clto_field

// file: clto_lane_timing.sv
// lane timing override registers with the lane entry/exit sequencer
`timescale 1ns/100ps
`include "clto_map.svh"
//
// Overview of operation
// - clock prepare auto, or override value when set
// - clock zero auto, or override value when set
// - clock trail auto, or override value when set
// - clock post auto, or override value when set
// - data prepare auto, or override value when set
// - data zero auto, or override value when set
// - data trail auto, or override value when set
// - override off: value reads auto, ignores writes with the override bit clear
// - override on: value writable, reads stored value
// - reset clears override bits and values

module clto_lane_timing #(
    parameter int UI_DIV = `CLTO_UI_DIV,
    parameter clto_pkg::clto_timing_t AUTO_BASE = '{
        data_trail:   7'h08,
        data_zero:    7'h0c,
        data_prepare: 7'h06,
        clk_post:     7'h10,
        clk_trail:    7'h08,
        clk_zero:     7'h20,
        clk_prepare:  7'h05
    }
) (
    input  wire logic       CORE_CLK,
    input  wire logic       RESET_N,
    input  wire logic [7:0] REG_PAGE,
    input  wire logic [7:0] REG_ADDR,
    input  wire logic [7:0] REG_WDATA,
    input  wire logic       REG_WR,
    input  wire logic       REG_RD,
    input  wire logic [1:0] RATE_SEL,
    input  wire logic       HS_REQ,
    output logic [7:0]      REG_RDATA,
    output logic            REG_RVALID,
    output logic            CLK_HS_EN,
    output logic            DATA_HS_EN,
    output logic            HS_READY,
    output logic            LP_STOP,
    output logic [8:0]      SEQ_STATE
);

    // reset release through two flops
    logic rst_meta_n_reg;
    logic rst_sync_n_reg;
    logic rst_n;

    always_ff @(posedge CORE_CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            rst_meta_n_reg <= 1'b0;
            rst_sync_n_reg <= 1'b0;
        end else begin
            rst_meta_n_reg <= 1'b1;
            rst_sync_n_reg <= rst_meta_n_reg;
        end
    end

    assign rst_n = rst_sync_n_reg;

    // register port request
    clto_pkg::clto_bus_req_t req;

    assign req.wr    = REG_WR;
    assign req.rd    = REG_RD;
    assign req.page  = REG_PAGE;
    assign req.addr  = REG_ADDR;
    assign req.wdata = REG_WDATA;

    logic page_hit;
    logic wr_stb;

    assign page_hit = (req.page == `CLTO_PAGE);
    assign wr_stb   = req.wr & page_hit;

    // automatic values
    clto_pkg::clto_timing_t auto_val;
    logic [6:0][6:0]        auto_arr;

    clto_auto #(
        .BASE     (AUTO_BASE)
    ) u_auto (
        .clk      (CORE_CLK),
        .rst_n    (rst_n),
        .rate_sel (RATE_SEL),
        .auto_val (auto_val)
    );

    assign auto_arr = auto_val;

    // seven timing registers
    logic [6:0]      field_hit;
    logic [6:0][7:0] field_rd;
    logic [6:0][6:0] eff_arr;

    genvar i;
    generate
        for (i = 0; i < `CLTO_NUM_REGS; i = i + 1) begin : g_field
            clto_field #(
                .ADDR     (8'(`CLTO_CLK_PREPARE_OFF + i))
            ) u_field (
                .clk      (CORE_CLK),
                .rst_n    (rst_n),
                .wr_stb   (wr_stb),
                .addr     (req.addr),
                .wdata    (req.wdata),
                .auto_val (auto_arr[i]),
                .hit      (field_hit[i]),
                .rd_byte  (field_rd[i]),
                .eff_val  (eff_arr[i])
            );
        end
    endgenerate

    clto_pkg::clto_timing_t eff;

    assign eff = clto_pkg::clto_timing_t'(eff_arr);

    // read select
    logic [7:0] rd_sel;
    logic [7:0] rdata_next;
    logic       rvalid_next;
    logic [7:0] rdata_reg;
    logic       rvalid_reg;

    assign rd_sel =
        !page_hit    ? `CLTO_UNMAPPED_RDATA :
        field_hit[0] ? field_rd[0] :
        field_hit[1] ? field_rd[1] :
        field_hit[2] ? field_rd[2] :
        field_hit[3] ? field_rd[3] :
        field_hit[4] ? field_rd[4] :
        field_hit[5] ? field_rd[5] :
        field_hit[6] ? field_rd[6] :
        `CLTO_UNMAPPED_RDATA;

    assign rdata_next  = req.rd ? rd_sel : rdata_reg;
    assign rvalid_next = req.rd;

    always_ff @(posedge CORE_CLK or negedge rst_n) begin
        if (!rst_n) begin
            rdata_reg  <= 8'h00;
            rvalid_reg <= 1'b0;
        end else begin
            rdata_reg  <= rdata_next;
            rvalid_reg <= rvalid_next;
        end
    end

    assign REG_RDATA  = rdata_reg;
    assign REG_RVALID = rvalid_reg;

    // byte tick divider
    logic [7:0] div_reg;
    logic [7:0] div_next;
    logic       tick;

    assign tick     = (div_reg == 8'(UI_DIV - 1));
    assign div_next = tick ? 8'h00 : div_reg + 8'h01;

    always_ff @(posedge CORE_CLK or negedge rst_n) begin
        if (!rst_n) begin
            div_reg <= 8'h00;
        end else begin
            div_reg <= div_next;
        end
    end

    // lane sequencer
    clto_pkg::clto_state_t state_reg;
    clto_pkg::clto_state_t state_next;
    logic [6:0]            cnt_reg;
    logic [6:0]            cnt_next;
    logic                  load;
    logic                  phase_end;
    logic [6:0]            raw_len;
    logic [6:0]            phase_len;

    assign phase_end = tick & (cnt_reg == `CLTO_MIN_PHASE);

    always_comb begin
        state_next = state_reg;
        load       = 1'b0;
        case (state_reg)
            clto_pkg::CLTO_IDLE: begin
                if (HS_REQ) begin
                    state_next = clto_pkg::CLTO_CLK_PREP;
                    load       = 1'b1;
                end
            end
            clto_pkg::CLTO_CLK_PREP: begin
                if (phase_end) begin
                    state_next = clto_pkg::CLTO_CLK_ZERO;
                    load       = 1'b1;
                end
            end
            clto_pkg::CLTO_CLK_ZERO: begin
                if (phase_end) begin
                    state_next = clto_pkg::CLTO_DATA_PREP;
                    load       = 1'b1;
                end
            end
            clto_pkg::CLTO_DATA_PREP: begin
                if (phase_end) begin
                    state_next = clto_pkg::CLTO_DATA_ZERO;
                    load       = 1'b1;
                end
            end
            clto_pkg::CLTO_DATA_ZERO: begin
                if (phase_end) begin
                    state_next = clto_pkg::CLTO_HS_DATA;
                end
            end
            clto_pkg::CLTO_HS_DATA: begin
                if (!HS_REQ) begin
                    state_next = clto_pkg::CLTO_DATA_TRAIL;
                    load       = 1'b1;
                end
            end
            clto_pkg::CLTO_DATA_TRAIL: begin
                if (phase_end) begin
                    state_next = clto_pkg::CLTO_CLK_POST;
                    load       = 1'b1;
                end
            end
            clto_pkg::CLTO_CLK_POST: begin
                if (phase_end) begin
                    state_next = clto_pkg::CLTO_CLK_TRAIL;
                    load       = 1'b1;
                end
            end
            clto_pkg::CLTO_CLK_TRAIL: begin
                if (phase_end) begin
                    state_next = clto_pkg::CLTO_IDLE;
                end
            end
            default: begin
                state_next = clto_pkg::CLTO_IDLE;
            end
        endcase
    end

    // length of the phase being entered, sampled at entry
    assign raw_len =
        (state_next == clto_pkg::CLTO_CLK_PREP)   ? eff.clk_prepare :
        (state_next == clto_pkg::CLTO_CLK_ZERO)   ? eff.clk_zero :
        (state_next == clto_pkg::CLTO_DATA_PREP)  ? eff.data_prepare :
        (state_next == clto_pkg::CLTO_DATA_ZERO)  ? eff.data_zero :
        (state_next == clto_pkg::CLTO_DATA_TRAIL) ? eff.data_trail :
        (state_next == clto_pkg::CLTO_CLK_POST)   ? eff.clk_post :
        (state_next == clto_pkg::CLTO_CLK_TRAIL)  ? eff.clk_trail :
        `CLTO_MIN_PHASE;

    // a zero setting still lasts one tick
    assign phase_len = (raw_len == 7'h00) ? `CLTO_MIN_PHASE : raw_len;

    assign cnt_next = load ? phase_len :
                      (tick && cnt_reg != `CLTO_MIN_PHASE) ? cnt_reg - 7'h01 :
                      cnt_reg;

    always_ff @(posedge CORE_CLK or negedge rst_n) begin
        if (!rst_n) begin
            state_reg <= clto_pkg::CLTO_IDLE;
            cnt_reg   <= `CLTO_MIN_PHASE;
        end else begin
            state_reg <= state_next;
            cnt_reg   <= cnt_next;
        end
    end

    // lane controls registered from the next state
    logic clk_hs_next;
    logic data_hs_next;
    logic ready_next;
    logic stop_next;
    logic clk_hs_reg;
    logic data_hs_reg;
    logic ready_reg;
    logic stop_reg;
    logic [8:0] seq_reg;

    assign clk_hs_next  = (state_next == clto_pkg::CLTO_CLK_ZERO)
                        | (state_next == clto_pkg::CLTO_DATA_PREP)
                        | (state_next == clto_pkg::CLTO_DATA_ZERO)
                        | (state_next == clto_pkg::CLTO_HS_DATA)
                        | (state_next == clto_pkg::CLTO_DATA_TRAIL)
                        | (state_next == clto_pkg::CLTO_CLK_POST);
    assign data_hs_next = (state_next == clto_pkg::CLTO_DATA_ZERO)
                        | (state_next == clto_pkg::CLTO_HS_DATA)
                        | (state_next == clto_pkg::CLTO_DATA_TRAIL);
    assign ready_next   = (state_next == clto_pkg::CLTO_HS_DATA);
    assign stop_next    = (state_next == clto_pkg::CLTO_IDLE);

    always_ff @(posedge CORE_CLK or negedge rst_n) begin
        if (!rst_n) begin
            clk_hs_reg  <= 1'b0;
            data_hs_reg <= 1'b0;
            ready_reg   <= 1'b0;
            stop_reg    <= 1'b1;
            seq_reg     <= 9'h001;
        end else begin
            clk_hs_reg  <= clk_hs_next;
            data_hs_reg <= data_hs_next;
            ready_reg   <= ready_next;
            stop_reg    <= stop_next;
            seq_reg     <= state_next;
        end
    end

    assign CLK_HS_EN  = clk_hs_reg;
    assign DATA_HS_EN = data_hs_reg;
    assign HS_READY   = ready_reg;
    assign LP_STOP    = stop_reg;
    assign SEQ_STATE  = seq_reg;

endmodule : clto_lane_timing

// file: clto_map.svh
// register map, field positions, reset values and timing counts
`ifndef CLTO_MAP_SVH
`define CLTO_MAP_SVH

`define CLTO_PAGE              8'h00
`define CLTO_CLK_PREPARE_OFF   8'h40
`define CLTO_CLK_ZERO_OFF      8'h41
`define CLTO_CLK_TRAIL_OFF     8'h42
`define CLTO_CLK_POST_OFF      8'h43
`define CLTO_DATA_PREPARE_OFF  8'h44
`define CLTO_DATA_ZERO_OFF     8'h45
`define CLTO_DATA_TRAIL_OFF    8'h46
`define CLTO_NUM_REGS          7
`define CLTO_OV_BIT            7
`define CLTO_VAL_MSB           6
`define CLTO_VAL_LSB           0
`define CLTO_OV_RESET          1'b0
`define CLTO_VAL_RESET         7'h00
`define CLTO_UNMAPPED_RDATA    8'h00
`define CLTO_MIN_PHASE         7'h01
`define CLTO_UI_DIV            4

`endif

// file: clto_monitor.sv
// concurrent checks on the lane timing block ports
`timescale 1ns/100ps
module clto_monitor #(
    parameter int UI_DIV = 4
) (
    input wire logic       CORE_CLK,
    input wire logic       RESET_N,
    input wire logic [7:0] REG_PAGE,
    input wire logic [7:0] REG_ADDR,
    input wire logic [7:0] REG_WDATA,
    input wire logic       REG_WR,
    input wire logic       REG_RD,
    input wire logic       HS_REQ,
    input wire logic [7:0] REG_RDATA,
    input wire logic       REG_RVALID,
    input wire logic       CLK_HS_EN,
    input wire logic       DATA_HS_EN,
    input wire logic       HS_READY,
    input wire logic       LP_STOP,
    input wire logic [8:0] SEQ_STATE
);
    localparam int PH_MAX = 128 * UI_DIV;
    wire hit = (REG_PAGE == 8'h00) && (REG_ADDR inside {[8'h40:8'h46]});
    default clocking cb @(posedge CORE_CLK); endclocking
    default disable iff (!RESET_N);

    sequence s_wr(logic ov);
        REG_WR && !REG_RD && hit && (REG_WDATA[7] == ov);
    endsequence
    sequence s_rd_same;
        REG_RD && !REG_WR && hit && $stable(REG_ADDR);
    endsequence

    a_rd_answer: assert property (REG_RD |=> REG_RVALID)
        else $error("read not answered");
    a_rvalid_cause: assert property (REG_RVALID |-> $past(REG_RD))
        else $error("read valid without read");
    a_unmapped_zero: assert property (REG_RD && !hit |=> REG_RDATA == 8'h00)
        else $error("unmapped read not zero");
    a_ov_readback: assert property (
        s_wr(1'b1) ##1 s_rd_same |=> REG_RDATA == $past(REG_WDATA, 2))
        else $error("override value not read back");
    a_ro_flag: assert property (s_wr(1'b0) ##1 s_rd_same |=> !REG_RDATA[7])
        else $error("override flag set by clearing write");
    a_phase_order: assert property ($changed(SEQ_STATE) |-> SEQ_STATE ==
        (($past(SEQ_STATE) == 9'h100) ? 9'h001 : $past(SEQ_STATE) << 1))
        else $error("phase order broken");
    a_phase_ends: assert property ($changed(SEQ_STATE) &&
        !(SEQ_STATE inside {9'h001, 9'h020}) |=> ##[0:PH_MAX] $changed(SEQ_STATE))
        else $error("phase too long");
    a_req_start: assert property (
        LP_STOP && HS_REQ |=> SEQ_STATE == 9'h002 && !LP_STOP)
        else $error("request not taken");
    a_lane_state: assert property (
        CLK_HS_EN == (SEQ_STATE inside {[9'h004:9'h080]}) &&
        DATA_HS_EN == (SEQ_STATE inside {9'h010, 9'h020, 9'h040}))
        else $error("lane enables disagree with phase");
    a_ready_stop: assert property (
        HS_READY == (SEQ_STATE == 9'h020) && LP_STOP == (SEQ_STATE == 9'h001))
        else $error("ready or stop disagree with phase");
endmodule : clto_monitor

// file: clto_pkg.sv
// shared types of the lane timing override block
package clto_pkg;

    typedef logic [6:0] clto_val_t;

    // member order puts register index 0 in the low bits
    typedef struct packed {
        clto_val_t data_trail;
        clto_val_t data_zero;
        clto_val_t data_prepare;
        clto_val_t clk_post;
        clto_val_t clk_trail;
        clto_val_t clk_zero;
        clto_val_t clk_prepare;
    } clto_timing_t;

    typedef struct packed {
        logic       wr;
        logic       rd;
        logic [7:0] page;
        logic [7:0] addr;
        logic [7:0] wdata;
    } clto_bus_req_t;

    typedef enum logic [8:0] {
        CLTO_IDLE       = 9'h001,
        CLTO_CLK_PREP   = 9'h002,
        CLTO_CLK_ZERO   = 9'h004,
        CLTO_DATA_PREP  = 9'h008,
        CLTO_DATA_ZERO  = 9'h010,
        CLTO_HS_DATA    = 9'h020,
        CLTO_DATA_TRAIL = 9'h040,
        CLTO_CLK_POST   = 9'h080,
        CLTO_CLK_TRAIL  = 9'h100
    } clto_state_t;

endpackage : clto_pkg

// file: clto_rx_model.sv
// downstream receiver model timing each lane phase
`timescale 1ns/100ps
module clto_rx_model (
    input  wire logic        clk,
    input  wire logic        rst_n,
    input  wire logic [8:0]  seq_state,
    output logic      [15:0] len [9]
);
    logic [8:0]  last_reg;
    logic [15:0] cnt_reg;
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            last_reg <= 9'h001;
            cnt_reg <= 16'h0001;
            for (int i = 0; i < 9; i++) len[i] <= 16'h0000;
        end else if (seq_state != last_reg) begin
            for (int i = 0; i < 9; i++) if (last_reg[i]) len[i] <= cnt_reg;
            cnt_reg <= 16'h0001;
            last_reg <= seq_state;
        end else begin
            cnt_reg <= cnt_reg + 16'h0001;
        end
    end
endmodule : clto_rx_model

// file: clto_tb.sv
// testbench for the lane timing override block
`timescale 1ns/100ps
module tb;
    localparam clto_pkg::clto_timing_t BASE = {7'h03, 7'h05, 7'h02,
        7'h04, 7'h03, 7'h21, 7'h02};
    localparam int PH [7] = '{1, 2, 8, 7, 3, 4, 6};
    logic        CORE_CLK;
    logic        RESET_N;
    logic [7:0]  REG_PAGE;
    logic [7:0]  REG_ADDR;
    logic [7:0]  REG_WDATA;
    logic        REG_WR;
    logic        REG_RD;
    logic [1:0]  RATE_SEL;
    logic        HS_REQ;
    logic [7:0]  REG_RDATA;
    logic        REG_RVALID;
    logic        CLK_HS_EN;
    logic        DATA_HS_EN;
    logic        HS_READY;
    logic        LP_STOP;
    logic [8:0]  SEQ_STATE;
    logic [15:0] len [9];
    int          num_errors = 0;
    int          cmp_count = 0;
    int          cyc = 0;

    clto_lane_timing #(.UI_DIV(1), .AUTO_BASE(BASE)) dut_u (
        .CORE_CLK(CORE_CLK), .RESET_N(RESET_N), .REG_PAGE(REG_PAGE),
        .REG_ADDR(REG_ADDR), .REG_WDATA(REG_WDATA), .REG_WR(REG_WR),
        .REG_RD(REG_RD), .RATE_SEL(RATE_SEL), .HS_REQ(HS_REQ),
        .REG_RDATA(REG_RDATA), .REG_RVALID(REG_RVALID),
        .CLK_HS_EN(CLK_HS_EN), .DATA_HS_EN(DATA_HS_EN),
        .HS_READY(HS_READY), .LP_STOP(LP_STOP), .SEQ_STATE(SEQ_STATE));
    clto_rx_model rx_u (.clk(CORE_CLK), .rst_n(RESET_N),
        .seq_state(SEQ_STATE), .len(len));

    task automatic give_verdict;
        $display("errors %0d compares %0d", num_errors, cmp_count);
        if (num_errors == 0 && cmp_count > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask : give_verdict

    task automatic check(input string name, input logic [15:0] seen,
                         input logic [15:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            num_errors++;
            $display("Error %s expected %h seen %h", name, exp, seen);
        end
    endtask : check

    // drive one bus cycle, return at the next falling edge
    task automatic bus(input logic w, input logic r, input logic [7:0] p,
                       input logic [7:0] a, input logic [7:0] d);
        REG_WR = w;
        REG_RD = r;
        REG_PAGE = p;
        REG_ADDR = a;
        REG_WDATA = d;
        @(negedge CORE_CLK);
    endtask : bus

    task automatic rd(input logic [7:0] p, a, exp);
        bus(1'b0, 1'b1, p, a, 8'h00);
        check("rvalid", {15'h0, REG_RVALID}, 16'h1);
        check("rdata", {8'h0, REG_RDATA}, {8'h0, exp});
    endtask : rd

    function automatic logic [6:0] auto_v(input int i);
        int v;
        v = int'(BASE[7*i +: 7]) * (int'(RATE_SEL) + 1);
        return (v > 127) ? 7'h7f : v[6:0];
    endfunction : auto_v

    task automatic t_reset;
        for (int i = 0; i < 7; i++)
            rd(8'h00, 8'h40 + 8'(i), {1'b0, auto_v(i)});
        bus(1'b0, 1'b0, 8'h00, 8'h00, 8'h00);
    endtask : t_reset

    task automatic t_readonly;
        RATE_SEL = 2'h3;
        repeat (3) @(negedge CORE_CLK);
        for (int i = 0; i < 7; i++) begin
            bus(1'b1, 1'b0, 8'h00, 8'h40 + 8'(i), 8'h15);
            rd(8'h00, 8'h40 + 8'(i), {1'b0, auto_v(i)});
        end
        bus(1'b0, 1'b0, 8'h00, 8'h00, 8'h00);
    endtask : t_readonly

    task automatic t_override;
        RATE_SEL = 2'h1;
        for (int i = 0; i < 7; i++) begin
            bus(1'b1, 1'b0, 8'h00, 8'h40 + 8'(i), 8'h80 | 8'(i));
            rd(8'h00, 8'h40 + 8'(i), 8'h80 | 8'(i));
        end
        bus(1'b1, 1'b0, 8'h01, 8'h40, 8'hff);
        rd(8'h01, 8'h40, 8'h00);
        rd(8'h00, 8'h47, 8'h00);
        rd(8'h00, 8'h40, 8'h80);
        bus(1'b0, 1'b0, 8'h00, 8'h00, 8'h00);
    endtask : t_override

    // one entry and exit of high speed, phases timed by the receiver
    task automatic t_seq(input logic ov);
        int         n;
        logic [6:0] e;
        HS_REQ = 1'b1;
        for (n = 0; n < 2000 && HS_READY !== 1'b1; n++) @(negedge CORE_CLK);
        check("ready", {15'h0, HS_READY}, 16'h1);
        check("clk_hs", {15'h0, CLK_HS_EN}, 16'h1);
        check("data_hs", {15'h0, DATA_HS_EN}, 16'h1);
        repeat (4) @(negedge CORE_CLK);
        HS_REQ = 1'b0;
        for (n = 0; n < 2000 && LP_STOP !== 1'b1; n++) @(negedge CORE_CLK);
        check("stop", {15'h0, LP_STOP}, 16'h1);
        check("clk_lp", {15'h0, CLK_HS_EN}, 16'h0);
        check("data_lp", {15'h0, DATA_HS_EN}, 16'h0);
        // receiver logs the last phase one edge after idle returns
        @(negedge CORE_CLK);
        for (int i = 0; i < 7; i++) begin
            e = ov ? 7'(i) : auto_v(i);
            if (e == 7'h00) e = 7'h01;
            check("phase", len[PH[i]], {9'h0, e});
        end
    endtask : t_seq

    task automatic t_clear;
        for (int i = 0; i < 7; i++) begin
            bus(1'b1, 1'b0, 8'h00, 8'h40 + 8'(i), 8'h00);
            rd(8'h00, 8'h40 + 8'(i), {1'b0, auto_v(i)});
        end
        // sequence at another rate class, auto values settle in one edge
        RATE_SEL = 2'h2;
        bus(1'b0, 1'b0, 8'h00, 8'h00, 8'h00);
        t_seq(1'b0);
    endtask : t_clear

    initial begin
        CORE_CLK = 1'b0;
        forever #12.5 CORE_CLK = ~CORE_CLK;
    end

    always @(posedge CORE_CLK) begin
        cyc++;
        if (cyc == 5000) begin
            num_errors++;
            give_verdict();
        end
    end

    initial begin
        RESET_N = 1'b0;
        REG_PAGE = 8'h00;
        REG_ADDR = 8'h00;
        REG_WDATA = 8'h00;
        REG_WR = 1'b0;
        REG_RD = 1'b0;
        RATE_SEL = 2'h0;
        HS_REQ = 1'b0;
        repeat (10) @(negedge CORE_CLK);
        RESET_N = 1'b1;
        repeat (3) @(negedge CORE_CLK);
        t_reset();
        t_readonly();
        t_override();
        t_seq(1'b1);
        t_clear();
        give_verdict();
    end
endmodule : tb

bind clto_lane_timing clto_monitor #(.UI_DIV(UI_DIV)) mon_u (
    .CORE_CLK(CORE_CLK), .RESET_N(RESET_N), .REG_PAGE(REG_PAGE),
    .REG_ADDR(REG_ADDR), .REG_WDATA(REG_WDATA), .REG_WR(REG_WR),
    .REG_RD(REG_RD), .HS_REQ(HS_REQ), .REG_RDATA(REG_RDATA),
    .REG_RVALID(REG_RVALID), .CLK_HS_EN(CLK_HS_EN),
    .DATA_HS_EN(DATA_HS_EN), .HS_READY(HS_READY), .LP_STOP(LP_STOP),
    .SEQ_STATE(SEQ_STATE));
